// *** bench/iect_event_src.sv ***
`timescale 1ns/1ps
// Event pin source: bursts of rising edges on request
module iect_event_src (
	input  wire logic       clk,  // Bench clock
	input  wire logic       rst,  // Async reset, high
	input  wire logic       go,   // Start a burst
	input  wire logic [7:0] n,    // Edges in the burst
	output logic            pin,  // Event pin, idles low
	output logic            busy  // Burst in progress
);
	logic [7:0] left_ff;
	logic [2:0] ph_ff;

	// Four clocks high, four low per edge, only on this pin
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			left_ff <= 8'h00;
			ph_ff   <= 3'h0;
			pin     <= 1'b0;
			busy    <= 1'b0;
		end else if (!busy && go) begin
			left_ff <= n;
			ph_ff   <= 3'h0;
			busy    <= (n != 8'h00);
		end else if (busy) begin
			ph_ff <= ph_ff + 3'h1;
			pin   <= (ph_ff < 3'h4);
			if (ph_ff == 3'h7) begin
				left_ff <= left_ff - 8'h01;
				busy    <= (left_ff != 8'h01);
			end
		end
	end
endmodule

// *** bench/iect_timer_test.sv ***
`timescale 1ns/1ps
// Self-checking bench for the interval / event count timer
module iect_timer_test;
	logic        clk;
	logic        rst;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [4:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        pin;
	logic        go;
	logic [7:0]  ne;
	logic        busy;
	logic        wave_out_0;
	logic        wave_out_1;
	logic        cycle_match_irq;
	logic        second_match_irq;
	logic        overflow_irq;
	logic [32:0] rq[$];
	logic [31:0] rdv;
	logic        w;
	int          mismatches;
	int          comparisons;
	int          c0;
	int          c1;
	int          ov;
	int          since;
	int          gap;
	int          a;
	int          b;
	int          k;
	int          tries;
	int          seed;

	iect_timer #(.PRE_W(3)) iect_timer_i (
		.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.trigger_in_0(pin), .wave_out_0(wave_out_0), .wave_out_1(wave_out_1),
		.cycle_match_irq(cycle_match_irq), .second_match_irq(second_match_irq),
		.overflow_irq(overflow_irq));
	iect_event_src iect_event_src_i (.clk(clk), .rst(rst), .go(go), .n(ne), .pin(pin), .busy(busy));

	// 20 MHz clock
	always #25 clk = ~clk;

	// Pulse counters and cycle match spacing, off the sampling edge
	always @(negedge clk) begin
		since++;
		if (cycle_match_irq === 1'b1) begin
			c0++;
			gap = since;
			since = 0;
		end
		if (second_match_irq === 1'b1) c1++;
		if (overflow_irq === 1'b1) ov++;
	end

	task automatic tally_and_finish();
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic hang();
		mismatches++;
		tally_and_finish();
	endtask

	// Read data checker: oldest note against each read acknowledge
	always @(posedge clk) begin
		if (wb_ack_o === 1'b1 && we === 1'b0) begin
			rdv = wb_dat_o;
			if (rq.size() == 0) begin
				hang();
			end else begin
				if (!rq[0][32]) chk(wb_dat_o, rq[0][31:0]);
				void'(rq.pop_front());
			end
		end
	end

	// Classic Wishbone single cycle, held until ack is sampled
	task automatic bus(input logic wr, input logic [4:0] ad, input logic [31:0] d, input logic [32:0] e);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= wr;
		adr <= ad;
		dat <= d;
		sel <= 4'hF;
		if (!wr) rq.push_back(e);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 50) hang();
	endtask

	task automatic wr(input logic [4:0] ad, input logic [31:0] d);
		bus(1'b1, ad, d, 33'h000000000);
	endtask

	task automatic rd(input logic [4:0] ad, input logic [31:0] e);
		bus(1'b0, ad, 32'h00000000, {1'b0, e});
	endtask

	task automatic wait_irq();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (cycle_match_irq !== 1'b1 && n < 70000);
		if (n >= 70000) hang();
	endtask

	// Burst of event edges, then settle through the pin synchroniser
	task automatic edges(input logic [7:0] n);
		@(posedge clk);
		go <= 1'b1;
		ne <= n;
		@(posedge clk);
		go <= 1'b0;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (busy !== 1'b0 && k < 200);
		repeat (6) @(posedge clk);
		if (k >= 200) hang();
	endtask

	// Interval run from stopped: start toggle, then match spacing
	task automatic ival(input int cc, input int ps);
		wr(iect_pkg::OFS_CTRL0, 32'h00000000);
		wr(iect_pkg::OFS_CC0, 32'(cc));
		w = wave_out_0;
		wr(iect_pkg::OFS_CTRL0, 32'((ps << 1) | 1));
		repeat (2) @(posedge clk);
		@(negedge clk);
		if (ps == 0 && cc > 2) chk(32'(wave_out_0), 32'(!w));
		wait_irq();
		wait_irq();
		chk(32'(gap), 32'((cc + 1) << ps));
	endtask

	// Main sequence
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 5'h00;
		sel = 4'h0;
		dat = 32'h00000000;
		go = 1'b0;
		ne = 8'h00;
		seed = 32'hcfa9f462;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(iect_pkg::OFS_CNT, 32'h00000000);
		rd(5'h1C, 32'h00000000);
		rd(iect_pkg::OFS_STAT, 32'h00000000);
		// Second match watched, not masked, to prove it is still raised
		wr(iect_pkg::OFS_CC1, 32'h00000001);
		wr(iect_pkg::OFS_IOC, 32'h00000003);
		ival(3, 0);
		a = c0;
		b = c1;
		w = wave_out_1;
		repeat (4) wait_irq();
		chk(32'(c1 - b), 32'(c0 - a));
		w = wave_out_0;
		wait_irq();
		chk(32'(wave_out_0), 32'(!w));
		w = wave_out_1;
		wait_irq();
		chk(32'(wave_out_1), 32'(!w));
		wr(iect_pkg::OFS_CC1, 32'h00000005);
		wait_irq();
		b = c1;
		w = wave_out_1;
		repeat (3) wait_irq();
		chk(32'(c1 - b), 32'h00000000);
		chk(32'(wave_out_1), 32'(w));
		ival(0, 0);
		rd(iect_pkg::OFS_CNT, 32'h00000000);
		ival(40, 0);
		wait_irq();
		bus(1'b0, iect_pkg::OFS_CNT, 32'h00000000, 33'h100000000);
		@(negedge clk);
		chk(32'(rdv > 0 && rdv < 8), 32'h00000001);
		repeat (4) ival(2 + $unsigned($random(seed)) % 8, $unsigned($random(seed)) % 3);
		ival(100, 0);
		wait_irq();
		repeat (50) @(posedge clk);
		wr(iect_pkg::OFS_CC0, 32'h0000000A);
		wait_irq();
		chk(32'(gap), 32'h0001000B);
		wr(iect_pkg::OFS_CTRL0, 32'h00000000);
		wr(iect_pkg::OFS_CNT, 32'h000000FF);
		rd(iect_pkg::OFS_CNT, 32'h00000000);
		// Event counting on rising edges
		wr(iect_pkg::OFS_CC0, 32'h00000002);
		wr(iect_pkg::OFS_CC1, 32'h00000000);
		wr(iect_pkg::OFS_IOC, 32'h00000007);
		wr(iect_pkg::OFS_CTRL1, 32'(iect_pkg::MODE_EVENT));
		wr(iect_pkg::OFS_CTRL0, 32'h00000001);
		w = wave_out_0;
		a = c0;
		tries = 0;
		while (c0 == a && tries < 10) begin
			edges(8'h01);
			tries++;
		end
		a = c0;
		b = c1;
		edges(8'h02);
		chk(32'(c0 - a), 32'h00000000);
		edges(8'h01);
		chk(32'(c0 - a), 32'h00000001);
		chk(32'(c1 - b), 32'h00000001);
		chk(32'(wave_out_0), 32'(w));
		chk(32'(ov), 32'h00000000);
		// Interval mode clocked by pin edges, both edges valid, drives wave 0
		wr(iect_pkg::OFS_CTRL0, 32'h00000000);
		wr(iect_pkg::OFS_CTRL1, 32'h00000020);
		wr(iect_pkg::OFS_IOC, 32'h0000000F);
		wr(iect_pkg::OFS_CC0, 32'h00000001);
		w = wave_out_0;
		wr(iect_pkg::OFS_CTRL0, 32'h00000001);
		edges(8'h01);
		chk(32'(wave_out_0), 32'(!w));
		a = c0;
		edges(8'h01);
		chk(32'(c0 - a), 32'h00000001);
		tally_and_finish();
	end
endmodule

// *** src/iect_edge_sync.sv ***
`timescale 1ns/1ps
// Two-flop synchroniser and selectable edge detector for the event pin
module iect_edge_sync (
	input  wire logic       clk,      // System clock
	input  wire logic       rst,      // Async reset, high
	input  wire logic       pin,      // Asynchronous event pin
	input  wire logic [1:0] edge_sel, // Valid edge select
	output logic            edge_p    // One-cycle valid edge pulse
);
	logic meta_ff;
	logic sync_ff;
	logic prev_ff;

	// Synchroniser and history
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			prev_ff <= 1'b0;
		end else begin
			meta_ff <= pin;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	// Edge qualification
	always_comb begin
		case (edge_sel)
			iect_pkg::EDGE_RISE: edge_p = sync_ff & ~prev_ff;
			iect_pkg::EDGE_FALL: edge_p = ~sync_ff & prev_ff;
			iect_pkg::EDGE_BOTH: edge_p = sync_ff ^ prev_ff;
			default:             edge_p = 1'b0;
		endcase
	end
endmodule

// *** src/iect_pkg.sv ***
// What this block does
// - Enabling counting moves counter FFFFH to 0000H, toggles output 0, loads cycle shadow.
// - Interval mode: counter equal to cycle shadow clears, toggles output 0, cycle match.
// - Interval mode period is cycle compare value plus one count clocks.
// - Second compare is always shadowed and raises second match on equality.
// - Cycle compare 0000H: match and toggle on every count clock from the second.
// - Cycle compare FFFFH: count to FFFFH, clear next, match, no overflow flag.
// - Cycle compare writes reach the shadow at once; lowering past count wraps.
// - Second compare below cycle compare: one second match per cycle, output 1 toggles.
// - Second compare above cycle compare: no second match, output 1 unchanged.
// - Mode code 001 counts valid external edges; output 0 unused there.
// - Event mode: enable clears counter to 0000H, edges increment, shadow loaded.
// - Event mode: cycle compare plus one edges clear counter, raise cycle match.
// - Event mode with FFFFH: count to FFFFH, clear next, match, no overflow flag.
// - Event mode: lowering cycle compare below count wraps before the match.
// - Event mode: second match once per cycle when below, never when above.
// - Counter readback register returns the current 16-bit count.
// - Counter readback reads 0000H while counting is disabled.
package iect_pkg;
	localparam int CNT_W = 16;
	localparam logic [15:0] CNT_IDLE = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	// Register byte offsets
	localparam logic [4:0] OFS_CTRL0 = 5'h00;
	localparam logic [4:0] OFS_CTRL1 = 5'h04;
	localparam logic [4:0] OFS_IOC   = 5'h08;
	localparam logic [4:0] OFS_CC0   = 5'h0C;
	localparam logic [4:0] OFS_CC1   = 5'h10;
	localparam logic [4:0] OFS_CNT   = 5'h14;
	localparam logic [4:0] OFS_STAT  = 5'h18;
	// Field positions
	localparam int CTRL0_RUN     = 0;
	localparam int CTRL0_PRE_LO  = 1;
	localparam int CTRL1_MODE_LO = 0;
	localparam int CTRL1_EXTCLK  = 5;
	localparam int IOC_OUT0_EN   = 0;
	localparam int IOC_OUT1_EN   = 1;
	localparam int IOC_EDGE_LO   = 2;
	// Mode codes
	localparam logic [2:0] MODE_INTERVAL = 3'h0;
	localparam logic [2:0] MODE_EVENT    = 3'h1;
	// Edge select codes
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;
	// Reset values
	localparam logic [3:0]  CTRL0_RST = 4'h0;
	localparam logic [5:0]  CTRL1_RST = 6'h00;
	localparam logic [3:0]  IOC_RST   = 4'h0;
	localparam logic [15:0] CC_RST    = 16'h0000;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_START = 3'b010,
		ST_RUN   = 3'b100
	} iect_state_e;
endpackage

// *** src/iect_prescaler.sv ***
`timescale 1ns/1ps
// Count clock enable: one pulse every 2^sel system clocks
module iect_prescaler #(
	parameter int SEL_W = 3 // Width of divider select
) (
	input  wire logic             clk,  // System clock
	input  wire logic             rst,  // Async reset, high
	input  wire logic             run,  // Divider runs while high
	input  wire logic [SEL_W-1:0] sel,  // Divide by 2^sel
	output logic                  tick  // One-cycle count enable
);
	localparam int DIV_W = (1 << SEL_W);
	logic [DIV_W-1:0] div_ff;
	logic [DIV_W-1:0] mask;

	if (SEL_W < 1 || SEL_W > 4) begin : g_bad_sel_w
		$error("iect_prescaler: SEL_W out of range");
	end

	// Free divider, restarted when stopped
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_ff <= '0;
		end else if (!run) begin
			div_ff <= '0;
		end else begin
			div_ff <= div_ff + 1'b1;
		end
	end

	// Tick when the selected low bits are all ones, one clock before they wrap to zero
	always_comb begin
		mask = DIV_W'((1 << sel) - 1);
		tick = run & ((div_ff & mask) == mask);
	end
endmodule

// *** src/iect_timer.sv ***
`timescale 1ns/1ps
// Interval / event count timer with classic Wishbone register access
module iect_timer #(
	parameter int PRE_W = 3 // Prescaler select width
) (
	input  wire logic        clk,              // System clock, 20 MHz
	input  wire logic        rst,              // Async reset, high
	input  wire logic        wb_cyc_i,         // Bus cycle
	input  wire logic        wb_stb_i,         // Strobe
	input  wire logic        wb_we_i,          // Write enable
	input  wire logic [4:0]  wb_adr_i,         // Byte address
	input  wire logic [3:0]  wb_sel_i,         // Byte lane selects
	input  wire logic [31:0] wb_dat_i,         // Write data
	output logic [31:0]      wb_dat_o,         // Read data
	output logic             wb_ack_o,         // Acknowledge
	input  wire logic        trigger_in_0,     // External event pin
	output logic             wave_out_0,       // Wave output 0
	output logic             wave_out_1,       // Wave output 1
	output logic             cycle_match_irq,  // Cycle match pulse
	output logic             second_match_irq, // Second match pulse
	output logic             overflow_irq      // Overflow pulse, unused here
);
	localparam int CNT_W = iect_pkg::CNT_W;

	if (PRE_W < 1 || PRE_W > 3) begin : g_bad_pre_w
		$error("iect_timer: PRE_W out of range");
	end

	// Registers
	logic                  count_run_bit_ff;
	logic [PRE_W-1:0]      pre_sel_ff;
	logic [2:0]            mode_select_field_ff;
	logic                  external_clock_select_ff;
	logic [3:0]            io_control_ff;
	logic [CNT_W-1:0]      cycle_compare_reg_ff;
	logic [CNT_W-1:0]      second_compare_reg_ff;
	logic [CNT_W-1:0]      cycle_compare_shadow_ff;
	logic [CNT_W-1:0]      second_compare_shadow_ff;
	logic [CNT_W-1:0]      cnt_ff;
	logic                  overflow_flag_ff;
	iect_pkg::iect_state_e state_ff;
	iect_pkg::iect_state_e nxt_state;
	logic                  ack_ff;
	logic [31:0]           dat_ff;
	logic                  wave0_ff;
	logic                  wave1_ff;
	logic                  cc0_irq_ff;
	logic                  cc1_irq_ff;

	// Decoded controls
	logic             bus_req;
	logic             wr_en;
	logic             mode_int;
	logic             mode_evt;
	logic             mode_ok;
	logic             evt_edge;
	logic             pre_tick;
	logic             tick;
	logic             run_tick;
	logic             hit0;
	logic             hit1;
	logic             out0_en;
	logic             out1_en;
	logic [CNT_W-1:0] count_readback;

	assign bus_req  = wb_cyc_i & wb_stb_i & ~ack_ff;
	assign wr_en    = bus_req & wb_we_i;
	assign mode_int = (mode_select_field_ff == iect_pkg::MODE_INTERVAL);
	assign mode_evt = (mode_select_field_ff == iect_pkg::MODE_EVENT);
	assign mode_ok  = mode_int | mode_evt;
	assign out0_en  = io_control_ff[iect_pkg::IOC_OUT0_EN];
	assign out1_en  = io_control_ff[iect_pkg::IOC_OUT1_EN];

	// Event pin synchroniser and edge select
	iect_edge_sync iect_edge_sync_i (
		.clk      (clk),
		.rst      (rst),
		.pin      (trigger_in_0),
		.edge_sel (io_control_ff[iect_pkg::IOC_EDGE_LO +: 2]),
		.edge_p   (evt_edge)
	);

	// Internal count clock divider
	iect_prescaler #(.SEL_W(PRE_W)) iect_prescaler_i (
		.clk  (clk),
		.rst  (rst),
		.run  (count_run_bit_ff),
		.sel  (pre_sel_ff),
		.tick (pre_tick)
	);

	// Count source: event edges in event mode or when external clock is chosen
	assign tick     = (mode_evt | external_clock_select_ff) ? evt_edge : pre_tick;
	assign run_tick = (state_ff == iect_pkg::ST_RUN) & tick;
	assign hit0     = run_tick & (cnt_ff == cycle_compare_shadow_ff);
	assign hit1     = run_tick & (cnt_ff == second_compare_shadow_ff);

	// Readback hides the idle FFFFH value
	assign count_readback = (state_ff == iect_pkg::ST_RUN) ? cnt_ff : iect_pkg::CNT_ZERO;

	// Wishbone acknowledge, one cycle per request
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= bus_req;
		end
	end

	// Read data capture
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dat_ff <= 32'h0000_0000;
		end else if (bus_req) begin
			case (wb_adr_i)
				iect_pkg::OFS_CTRL0: dat_ff <= 32'({pre_sel_ff, count_run_bit_ff});
				iect_pkg::OFS_CTRL1: dat_ff <= 32'({external_clock_select_ff, 2'h0, mode_select_field_ff});
				iect_pkg::OFS_IOC:   dat_ff <= 32'(io_control_ff);
				iect_pkg::OFS_CC0:   dat_ff <= 32'(cycle_compare_reg_ff);
				iect_pkg::OFS_CC1:   dat_ff <= 32'(second_compare_reg_ff);
				iect_pkg::OFS_CNT:   dat_ff <= 32'(count_readback);
				iect_pkg::OFS_STAT:  dat_ff <= 32'({wave1_ff, wave0_ff, overflow_flag_ff});
				default:             dat_ff <= 32'h0000_0000;
			endcase
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = dat_ff;

	// Control register writes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_run_bit_ff         <= iect_pkg::CTRL0_RST[0];
			pre_sel_ff               <= PRE_W'(iect_pkg::CTRL0_RST[3:1]);
			mode_select_field_ff     <= iect_pkg::CTRL1_RST[2:0];
			external_clock_select_ff <= iect_pkg::CTRL1_RST[5];
			io_control_ff            <= iect_pkg::IOC_RST;
		end else if (wr_en && wb_sel_i[0]) begin
			case (wb_adr_i)
				iect_pkg::OFS_CTRL0: begin
					count_run_bit_ff <= wb_dat_i[iect_pkg::CTRL0_RUN];
					pre_sel_ff       <= wb_dat_i[iect_pkg::CTRL0_PRE_LO +: PRE_W];
				end
				iect_pkg::OFS_CTRL1: begin
					mode_select_field_ff     <= wb_dat_i[iect_pkg::CTRL1_MODE_LO +: 3];
					external_clock_select_ff <= wb_dat_i[iect_pkg::CTRL1_EXTCLK];
				end
				iect_pkg::OFS_IOC: begin
					io_control_ff <= wb_dat_i[3:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Compare registers, byte lane writes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cycle_compare_reg_ff  <= iect_pkg::CC_RST;
			second_compare_reg_ff <= iect_pkg::CC_RST;
		end else if (wr_en) begin
			if (wb_adr_i == iect_pkg::OFS_CC0) begin
				if (wb_sel_i[0]) cycle_compare_reg_ff[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1]) cycle_compare_reg_ff[15:8] <= wb_dat_i[15:8];
			end
			if (wb_adr_i == iect_pkg::OFS_CC1) begin
				if (wb_sel_i[0]) second_compare_reg_ff[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1]) second_compare_reg_ff[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	// Shadows: loaded at start and follow every write while counting
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cycle_compare_shadow_ff  <= iect_pkg::CC_RST;
			second_compare_shadow_ff <= iect_pkg::CC_RST;
		end else if (state_ff == iect_pkg::ST_RUN) begin
			cycle_compare_shadow_ff  <= cycle_compare_reg_ff;
			second_compare_shadow_ff <= second_compare_reg_ff;
		end else if (nxt_state == iect_pkg::ST_RUN) begin
			cycle_compare_shadow_ff  <= cycle_compare_reg_ff;
			second_compare_shadow_ff <= second_compare_reg_ff;
		end
	end

	// Run sequencing
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			iect_pkg::ST_IDLE: begin
				if (count_run_bit_ff && mode_evt) begin
					nxt_state = iect_pkg::ST_RUN;
				end else if (count_run_bit_ff && mode_int) begin
					nxt_state = iect_pkg::ST_START;
				end
			end
			iect_pkg::ST_START: begin
				if (!count_run_bit_ff || !mode_ok) begin
					nxt_state = iect_pkg::ST_IDLE;
				end else if (tick) begin
					nxt_state = iect_pkg::ST_RUN;
				end
			end
			iect_pkg::ST_RUN: begin
				if (!count_run_bit_ff || !mode_ok) begin
					nxt_state = iect_pkg::ST_IDLE;
				end
			end
			default: nxt_state = iect_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= iect_pkg::ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Counter: FFFFH idle, cleared on start and on cycle match, else increments
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= iect_pkg::CNT_IDLE;
		end else if (nxt_state == iect_pkg::ST_IDLE) begin
			cnt_ff <= iect_pkg::CNT_IDLE;
		end else if (state_ff != iect_pkg::ST_RUN && nxt_state == iect_pkg::ST_RUN) begin
			cnt_ff <= iect_pkg::CNT_ZERO;
		end else if (hit0) begin
			cnt_ff <= iect_pkg::CNT_ZERO;
		end else if (run_tick) begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	// Overflow flag never set by these modes, even on FFFFH wrap
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			overflow_flag_ff <= 1'b0;
		end else if (wr_en && wb_adr_i == iect_pkg::OFS_STAT && wb_sel_i[0] && !wb_dat_i[0]) begin
			overflow_flag_ff <= 1'b0;
		end
	end

	assign overflow_irq = 1'b0;

	// Wave 0 toggles on start and cycle match, wave 1 on second match, in interval mode only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wave0_ff <= 1'b0;
			wave1_ff <= 1'b0;
		end else begin
			if (mode_int && out0_en && state_ff == iect_pkg::ST_START && nxt_state == iect_pkg::ST_RUN) begin
				wave0_ff <= ~wave0_ff;
			end else if (mode_int && out0_en && hit0) begin
				wave0_ff <= ~wave0_ff;
			end
			if (mode_int && out1_en && hit1) begin
				wave1_ff <= ~wave1_ff;
			end
		end
	end

	assign wave_out_0 = wave0_ff;
	assign wave_out_1 = wave1_ff;

	// Match pulses, one system clock each
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cc0_irq_ff <= 1'b0;
			cc1_irq_ff <= 1'b0;
		end else begin
			cc0_irq_ff <= hit0;
			cc1_irq_ff <= hit1;
		end
	end

	assign cycle_match_irq  = cc0_irq_ff;
	assign second_match_irq = cc1_irq_ff;

	// Checks
	property p_start_clear;
		@(posedge clk) disable iff (rst)
		(state_ff == iect_pkg::ST_START && tick && count_run_bit_ff && mode_int)
		|=> (state_ff == iect_pkg::ST_RUN && cnt_ff == 16'h0000);
	endproperty
	a_start_clear: assert property (p_start_clear) else $error("start did not clear counter");

	property p_match_clear;
		@(posedge clk) disable iff (rst)
		(run_tick && cnt_ff == cycle_compare_shadow_ff && count_run_bit_ff && mode_ok)
		|=> (cnt_ff == 16'h0000 && cycle_match_irq);
	endproperty
	a_match_clear: assert property (p_match_clear) else $error("cycle match missed");

	property p_irq_cause;
		@(posedge clk) disable iff (rst)
		cycle_match_irq |-> $past(run_tick) && $past(cnt_ff) == $past(cycle_compare_shadow_ff);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("cycle match without cause");

	property p_wave0_toggle;
		@(posedge clk) disable iff (rst)
		(hit0 && mode_int && out0_en) |=> (wave_out_0 != $past(wave_out_0));
	endproperty
	a_wave0_toggle: assert property (p_wave0_toggle) else $error("wave 0 did not toggle");

	property p_second_match;
		@(posedge clk) disable iff (rst)
		(run_tick && cnt_ff == second_compare_shadow_ff) |=> second_match_irq;
	endproperty
	a_second_match: assert property (p_second_match) else $error("second match missed");

	property p_readback_idle;
		@(posedge clk) disable iff (rst)
		(bus_req && !wb_we_i && wb_adr_i == iect_pkg::OFS_CNT && state_ff != iect_pkg::ST_RUN)
		|=> (wb_dat_o == 32'h0000_0000);
	endproperty
	a_readback_idle: assert property (p_readback_idle) else $error("readback not zero when stopped");

	property p_shadow_follow;
		@(posedge clk) disable iff (rst)
		(state_ff == iect_pkg::ST_RUN && wr_en && wb_adr_i == iect_pkg::OFS_CC0 && wb_sel_i[1:0] == 2'b11)
		##1 (state_ff == iect_pkg::ST_RUN) |=> (cycle_compare_shadow_ff == $past(wb_dat_i[15:0], 2));
	endproperty
	a_shadow_follow: assert property (p_shadow_follow) else $error("shadow did not follow write");

	property p_wrap_no_match;
		@(posedge clk) disable iff (rst)
		(run_tick && cnt_ff == 16'hFFFF && cycle_compare_shadow_ff != 16'hFFFF && count_run_bit_ff && mode_ok)
		|=> (cnt_ff == 16'h0000 && !cycle_match_irq && !overflow_flag_ff);
	endproperty
	a_wrap_no_match: assert property (p_wrap_no_match) else $error("wrap raised match or overflow");

	property p_event_start;
		@(posedge clk) disable iff (rst)
		(state_ff == iect_pkg::ST_IDLE && count_run_bit_ff && mode_evt)
		|=> (state_ff == iect_pkg::ST_RUN && cnt_ff == 16'h0000 && $stable(wave_out_0));
	endproperty
	a_event_start: assert property (p_event_start) else $error("event start wrong");

	property p_wave1_hold;
		@(posedge clk) disable iff (rst)
		!hit1 |=> $stable(wave_out_1);
	endproperty
	a_wave1_hold: assert property (p_wave1_hold) else $error("wave 1 changed without match");

	c_interval_match: cover property (@(posedge clk) disable iff (rst) mode_int && cycle_match_irq);
	c_event_match:    cover property (@(posedge clk) disable iff (rst) mode_evt && cycle_match_irq);
	c_second_match:   cover property (@(posedge clk) disable iff (rst) second_match_irq ##1 !second_match_irq);
	c_back_to_back:   cover property (@(posedge clk) disable iff (rst) cycle_match_irq ##1 cycle_match_irq);
endmodule
